/* include/acs_pkg.sv */
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ACS_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] ACS_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] ACS_OFF_TIMING = 8'h08;
    localparam logic [7:0] ACS_OFF_RES_HI = 8'h0c;
    localparam logic [7:0] ACS_OFF_RES_LO = 8'h10;
    localparam logic [7:0] ACS_OFF_STATUS = 8'h14;
    localparam logic [7:0] ACS_OFF_MASK = 8'h18;
    localparam logic [7:0] ACS_OFF_PINCFG = 8'h1c;
    localparam logic [7:0] ACS_OFF_SAMPLE = 8'h20;
    // Control zero fields
    localparam int ACS_C0_ON = 0;
    localparam int ACS_C0_GO = 1;
    localparam int ACS_C0_CHS_LSB = 2;
    // Control one fields
    localparam int ACS_C1_VPOS = 0;
    localparam int ACS_C1_VNEG = 1;
    localparam int ACS_C1_SLEEP = 2;
    // Timing control fields
    localparam int ACS_TC_JUSTIFY = 7;
    localparam int ACS_TC_ACQ_LSB = 3;
    localparam int ACS_TC_CLK_LSB = 0;
    localparam logic [7:0] ACS_TC_MASK = 8'hbf;
    // Reset values
    localparam logic [7:0] ACS_RST_CTRL0 = 8'h00;
    localparam logic [7:0] ACS_RST_CTRL1 = 8'h00;
    localparam logic [7:0] ACS_RST_TIMING = 8'h00;
    localparam logic [12:0] ACS_RST_PINCFG = 13'h0000;
    // Converter sizes
    localparam int ACS_RES_W = 12;
    localparam int ACS_CHAN_N = 13;
    // Instruction cycle: four system clocks
    localparam logic [7:0] ACS_TCY_CLKS = 8'h04;
    // Internal RC clock divider in system clocks
    localparam logic [7:0] ACS_RC_DIV = 8'h10;
    // Acquisition periods by code
    localparam logic [4:0] ACS_ACQ_TAB [8] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h14};
    // Conversion clock divisors by code, zero marks the RC clock
    localparam logic [7:0] ACS_DIV_TAB [8] = '{8'h02, 8'h08, 8'h20, 8'h00, 8'h04, 8'h10, 8'h40, 8'h00};
    // Sequencer states
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b000,
        ACS_DELAY = 3'b001,
        ACS_ACQ = 3'b010,
        ACS_CONV = 3'b011,
        ACS_DONE = 3'b100
    } acs_state_t;
endpackage

/* include/acs_clk_if.sv */
`timescale 1ns/1ps
interface acs_clk_if;
    logic run;
    logic [7:0] divisor;
    logic use_rc;
    logic tick;
    modport ctrl (output run, output divisor, output use_rc, input tick);
    modport gen (input run, input divisor, input use_rc, output tick);
endinterface

/* hw/acs_clk_gen.sv */
`timescale 1ns/1ps
module acs_clk_gen
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    acs_clk_if.gen cif
);
    logic [7:0] cnt_reg;
    logic [7:0] limit;
    logic rc_started_reg;

    // Divisor in force; RC clock first waits one instruction cycle
    always_comb begin
        if (cif.use_rc && !rc_started_reg) begin
            limit = ACS_TCY_CLKS;
        end else if (cif.use_rc) begin
            limit = ACS_RC_DIV;
        end else begin
            limit = cif.divisor;
        end
    end

    // Counter emitting one-cycle conversion clock ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            rc_started_reg <= 1'b0;
            cif.tick <= 1'b0;
        end else if (!cif.run) begin
            cnt_reg <= 8'h00;
            rc_started_reg <= 1'b0;
            cif.tick <= 1'b0;
        end else if (cnt_reg + 8'h01 >= limit) begin
            cnt_reg <= 8'h00;
            cif.tick <= rc_started_reg || !cif.use_rc;
            rc_started_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            cif.tick <= 1'b0;
        end
    end
endmodule

/* hw/acs_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Justify bit chooses right or left result
// - Acquisition code sets 0..20 clock periods
// - Clock code picks divider or RC clock
// - RC clock starts one instruction cycle late
// - Timing bit 6 reads zero; reset zero
// - References from rails or reference pins
// - Sleep conversion works on RC clock
// - Result built by successive approximation
// - Reset clears registers, aborts conversion
// - Done loads result, clears go, flags
// - Each converter pin analog or digital
// - Idle allowed mid-conversion; RC below 1MHz
// - Zero acquisition delays start one instruction cycle
module acs_top
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_mode,
    input wire logic cmp_high,
    output logic sample_hold,
    output logic [3:0] channel_select,
    output logic [ACS_RES_W-1:0] dac_code,
    output logic vref_pos_ext,
    output logic vref_neg_ext,
    output logic [ACS_CHAN_N-1:0] pin_analog,
    output logic conversion_busy,
    output logic irq
);
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] timing_reg;
    logic [7:0] res_hi_reg;
    logic [7:0] res_lo_reg;
    logic [ACS_CHAN_N-1:0] pincfg_reg;
    logic status_reg;
    logic mask_reg;
    acs_state_t state_reg;
    logic [4:0] count_reg;
    logic [ACS_RES_W-1:0] sar_reg;
    logic [ACS_RES_W-1:0] trial_reg;
    logic [3:0] bit_reg;
    logic [1:0] tcy_reg;
    logic wr_en;
    logic rd_en;
    logic done_evt;
    logic go_start;
    logic [2:0] acq_code;
    logic [2:0] clk_code;
    logic [ACS_RES_W-1:0] sar_next;
    logic [15:0] res_word;
    logic [31:0] rdata_next;
    logic sleep_stall;
    acs_clk_if cif();

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign acq_code = timing_reg[ACS_TC_ACQ_LSB +: 3];
    assign clk_code = timing_reg[ACS_TC_CLK_LSB +: 3];
    assign go_start = wr_en && paddr == ACS_OFF_CTRL0 && pwdata[ACS_C0_GO] && pwdata[ACS_C0_ON]
        && ctrl0_reg[ACS_C0_ON] && state_reg == ACS_IDLE;
    assign done_evt = state_reg == ACS_DONE;

    // Sleep halts system divider clocks but not the RC clock
    assign sleep_stall = sleep_mode && clk_code[1:0] != 2'b11;

    // Conversion clock generator drive
    assign cif.run = state_reg inside {ACS_ACQ, ACS_CONV} && !sleep_stall;
    assign cif.use_rc = clk_code[1:0] == 2'b11;
    assign cif.divisor = ACS_DIV_TAB[clk_code];

    acs_clk_gen u_clk_gen (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );

    // Control register zero: channel, go and enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_reg <= ACS_RST_CTRL0;
        end else if (done_evt) begin
            ctrl0_reg[ACS_C0_GO] <= 1'b0;
        end else if (wr_en && paddr == ACS_OFF_CTRL0) begin
            ctrl0_reg[ACS_C0_ON] <= pwdata[ACS_C0_ON];
            ctrl0_reg[ACS_C0_CHS_LSB +: 4] <= pwdata[ACS_C0_CHS_LSB +: 4];
            if (go_start) begin
                ctrl0_reg[ACS_C0_GO] <= 1'b1;
            end else if (!pwdata[ACS_C0_ON]) begin
                ctrl0_reg[ACS_C0_GO] <= 1'b0;
            end
        end
    end

    // Control one, timing control and pin configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_reg <= ACS_RST_CTRL1;
            timing_reg <= ACS_RST_TIMING;
            pincfg_reg <= ACS_RST_PINCFG;
        end else if (wr_en) begin
            if (paddr == ACS_OFF_CTRL1) begin
                ctrl1_reg <= pwdata[7:0] & 8'h07;
            end
            if (paddr == ACS_OFF_TIMING) begin
                timing_reg <= pwdata[7:0] & ACS_TC_MASK;
            end
            if (paddr == ACS_OFF_PINCFG) begin
                pincfg_reg <= pwdata[ACS_CHAN_N-1:0];
            end
        end
    end

    // Sequencer: delay, acquisition, approximation, done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ACS_IDLE;
            count_reg <= 5'h00;
            tcy_reg <= 2'h0;
        end else if (!ctrl0_reg[ACS_C0_ON] && state_reg != ACS_IDLE) begin
            state_reg <= ACS_IDLE;
        end else begin
            unique case (state_reg)
                ACS_IDLE: begin
                    if (go_start && acq_code == 3'b000) begin
                        state_reg <= ACS_DELAY;
                        tcy_reg <= 2'(ACS_TCY_CLKS - 8'h01);
                    end else if (go_start) begin
                        state_reg <= ACS_ACQ;
                        count_reg <= ACS_ACQ_TAB[acq_code];
                    end
                end
                ACS_DELAY: begin
                    if (tcy_reg == 2'h0) begin
                        state_reg <= ACS_CONV;
                    end else begin
                        tcy_reg <= tcy_reg - 2'h1;
                    end
                end
                ACS_ACQ: begin
                    if (cif.tick && count_reg == 5'h01) begin
                        state_reg <= ACS_CONV;
                    end else if (cif.tick) begin
                        count_reg <= count_reg - 5'h01;
                    end
                end
                ACS_CONV: begin
                    if (cif.tick && bit_reg == 4'h0) begin
                        state_reg <= ACS_DONE;
                    end
                end
                ACS_DONE: begin
                    state_reg <= ACS_IDLE;
                end
            endcase
        end
    end

    // Trial bit decision from comparator
    always_comb begin
        sar_next = sar_reg;
        if (cmp_high) begin
            sar_next = sar_reg | trial_reg;
        end
    end

    // Successive approximation register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_reg <= '0;
            trial_reg <= '0;
            bit_reg <= 4'h0;
        end else if (state_reg != ACS_CONV) begin
            sar_reg <= '0;
            trial_reg <= {1'b1, {(ACS_RES_W-1){1'b0}}};
            bit_reg <= 4'(ACS_RES_W - 1);
        end else if (cif.tick) begin
            sar_reg <= sar_next;
            trial_reg <= trial_reg >> 1;
            bit_reg <= bit_reg - 4'h1;
        end
    end

    // Result formatting by justification
    always_comb begin
        if (timing_reg[ACS_TC_JUSTIFY]) begin
            res_word = {4'h0, sar_next};
        end else begin
            res_word = {sar_next, 4'h0};
        end
    end

    // Result pair loads at the last trial
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_hi_reg <= 8'h00;
            res_lo_reg <= 8'h00;
        end else if (state_reg == ACS_CONV && cif.tick && bit_reg == 4'h0) begin
            res_hi_reg <= res_word[15:8];
            res_lo_reg <= res_word[7:0];
        end
    end

    // Sticky done flag, read clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            if (done_evt) begin
                status_reg <= 1'b1;
            end else if (rd_en && paddr == ACS_OFF_STATUS) begin
                status_reg <= 1'b0;
            end
            if (wr_en && paddr == ACS_OFF_MASK) begin
                mask_reg <= pwdata[0];
            end
        end
    end

    // Read data selection
    always_comb begin
        unique case (paddr)
            ACS_OFF_CTRL0: rdata_next = {24'h0, ctrl0_reg};
            ACS_OFF_CTRL1: rdata_next = {24'h0, ctrl1_reg};
            ACS_OFF_TIMING: rdata_next = {24'h0, timing_reg & ACS_TC_MASK};
            ACS_OFF_RES_HI: rdata_next = {24'h0, res_hi_reg};
            ACS_OFF_RES_LO: rdata_next = {24'h0, res_lo_reg};
            ACS_OFF_STATUS: rdata_next = {31'h0, status_reg};
            ACS_OFF_MASK: rdata_next = {31'h0, mask_reg};
            ACS_OFF_PINCFG: rdata_next = {19'h0, pincfg_reg};
            ACS_OFF_SAMPLE: rdata_next = {29'h0, state_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    // APB answer: ready in the setup cycle's next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0;
            pslverr <= psel && !penable && paddr > ACS_OFF_SAMPLE;
        end
    end

    // Converter side outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_hold <= 1'b0;
            channel_select <= 4'h0;
            dac_code <= '0;
            vref_pos_ext <= 1'b0;
            vref_neg_ext <= 1'b0;
            pin_analog <= '0;
            conversion_busy <= 1'b0;
            irq <= 1'b0;
        end else begin
            sample_hold <= state_reg inside {ACS_ACQ, ACS_DELAY} && ctrl0_reg[ACS_C0_ON]; // Drops with enable
            channel_select <= ctrl0_reg[ACS_C0_CHS_LSB +: 4];
            dac_code <= sar_reg | trial_reg;
            vref_pos_ext <= ctrl1_reg[ACS_C1_VPOS];
            vref_neg_ext <= ctrl1_reg[ACS_C1_VNEG];
            pin_analog <= pincfg_reg;
            conversion_busy <= ctrl0_reg[ACS_C0_GO];
            irq <= (status_reg || done_evt) && mask_reg;
        end
    end
endmodule

/* dv/acs_analog_model.sv */
`timescale 1ns/1ps
module acs_analog_model
    import acs_pkg::*;
(
    input wire logic [ACS_RES_W-1:0] dac_code,
    input wire logic [ACS_RES_W-1:0] level,
    output logic cmp_high
);
    // Comparator: input at or above the trial code keeps the bit
    assign cmp_high = (level >= dac_code);
endmodule

/* dv/acs_assertions.sv */
`timescale 1ns/1ps
module acs_assertions
    import acs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic sample_hold,
    input wire logic vref_pos_ext,
    input wire logic [ACS_CHAN_N-1:0] pin_analog,
    input wire logic conversion_busy,
    input wire logic irq
);
    logic wr_acc;
    logic go_acc;
    // Completed write access
    assign wr_acc = psel && penable && pwrite && pready;
    // Completed write that sets the go bit
    assign go_acc = wr_acc && paddr == ACS_OFF_CTRL0 && pwdata[ACS_C0_GO];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    reset_out_a: assert property (disable iff (1'b0) !presetn |-> !conversion_busy && !irq && !sample_hold)
        else $error("outputs not cleared in reset");
    bit6_zero_a: assert property (pready && !pwrite && paddr == ACS_OFF_TIMING |-> prdata[31:8] == 24'h0 && !prdata[6])
        else $error("timing read shows unimplemented bits");
    busy_start_a: assert property ($rose(conversion_busy) |-> $past(go_acc, 2))
        else $error("busy rose without go write");
    busy_hold_a: assert property ($rose(conversion_busy) |-> conversion_busy [*8])
        else $error("conversion ended too soon");
    irq_done_a: assert property ($rose(irq) |=> !conversion_busy)
        else $error("done flag while busy");
    sh_busy_a: assert property (sample_hold |-> conversion_busy)
        else $error("tracking outside conversion");
    ref_write_a: assert property ($changed(vref_pos_ext) |-> $past(wr_acc && paddr == ACS_OFF_CTRL1, 2))
        else $error("reference select changed without write");
    pin_write_a: assert property ($changed(pin_analog) |-> $past(wr_acc && paddr == ACS_OFF_PINCFG, 2))
        else $error("pin config changed without write");
endmodule
bind acs_top acs_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .sample_hold(sample_hold),
    .vref_pos_ext(vref_pos_ext), .pin_analog(pin_analog), .conversion_busy(conversion_busy), .irq(irq));

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    import acs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_mode, cmp_high;
    logic sample_hold, vref_pos_ext, vref_neg_ext, conversion_busy, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] channel_select;
    logic [ACS_RES_W-1:0] dac_code, level;
    logic [ACS_CHAN_N-1:0] pin_analog;
    int miscompares = 0;
    int check_count = 0;
    acs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
        .cmp_high(cmp_high), .sample_hold(sample_hold), .channel_select(channel_select), .dac_code(dac_code),
        .vref_pos_ext(vref_pos_ext), .vref_neg_ext(vref_neg_ext), .pin_analog(pin_analog),
        .conversion_busy(conversion_busy), .irq(irq));
    acs_analog_model far (.dac_code(dac_code), .level(level), .cmp_high(cmp_high));
    // Clock
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    task close_out;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Run limit
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        close_out;
    end
    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; close_out; end
        rdat = prdata;
        psel <= 0; penable <= 0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(0, a, 0);
        `CHK(nm, e, rdat)
    endtask
    // Timing reset value, bit 6, unmapped place, references, pin config
    task regs_scn;
        rd_chk(ACS_OFF_TIMING, 32'h0, "timing reset");
        apb(1, ACS_OFF_TIMING, 32'hff);
        rd_chk(ACS_OFF_TIMING, 32'hbf, "timing bit6");
        apb(0, 8'h24, 0);
        `CHK("unmapped data", 32'h0, rdat)
        `CHK("unmapped error", 1'b1, pslverr)
        apb(1, ACS_OFF_CTRL1, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK("ref select", 2'b11, {vref_pos_ext, vref_neg_ext})
        apb(1, ACS_OFF_PINCFG, 32'h1555);
        repeat (2) @(posedge pclk);
        `CHK("pin analog", 13'h1555, pin_analog)
    endtask
    // Full conversion with timing code t; checks duration, result, flag, irq
    task conv_scn(input logic [7:0] t, input logic [11:0] lv, input logic m, input logic s);
        int cnt, nexp, dv;
        logic [7:0] ehi, elo;
        dv = (ACS_DIV_TAB[t[2:0]] == 0) ? ACS_RC_DIV : ACS_DIV_TAB[t[2:0]];
        nexp = (ACS_ACQ_TAB[t[5:3]] + 12) * dv + ((t[5:3] == 0) ? ACS_TCY_CLKS : 0);
        nexp += (ACS_DIV_TAB[t[2:0]] == 0) ? ACS_TCY_CLKS : 0;
        level <= lv; sleep_mode <= s;
        apb(1, ACS_OFF_TIMING, {24'h0, t});
        apb(1, ACS_OFF_MASK, {31'h0, m});
        apb(1, ACS_OFF_CTRL0, 32'h1);
        apb(1, ACS_OFF_CTRL0, 32'h37);
        cnt = 0;
        // Busy shows one edge after go; clock setup and sleep held until done
        @(posedge pclk);
        #1;
        while (conversion_busy !== 1'b0 && cnt < 3000) begin
            @(posedge pclk);
            #1;
            cnt++;
        end
        if (cnt >= 3000) begin
            miscompares++;
            close_out;
        end
        `CHK("channel", 4'hd, channel_select)
        `CHK("duration", 1'b1, (cnt >= nexp - dv) && (cnt <= nexp + dv + 8))
        repeat (3) @(posedge pclk);
        `CHK("irq level", m, irq)
        ehi = t[7] ? {4'h0, lv[11:8]} : lv[11:4];
        elo = t[7] ? lv[7:0] : {lv[3:0], 4'h0};
        rd_chk(ACS_OFF_CTRL0, 32'h35, "go cleared");
        rd_chk(ACS_OFF_RES_HI, {24'h0, ehi}, "result high");
        rd_chk(ACS_OFF_RES_LO, {24'h0, elo}, "result low");
        rd_chk(ACS_OFF_STATUS, 32'h1, "done set");
        rd_chk(ACS_OFF_STATUS, 32'h0, "done cleared");
        `CHK("irq cleared", 1'b0, irq)
        sleep_mode <= 0;
    endtask
    // Go refused while off; clear of enable aborts; reset mid-run aborts
    task abort_scn;
        apb(1, ACS_OFF_CTRL0, 32'h0);
        apb(1, ACS_OFF_CTRL0, 32'h2);
        `CHK("go while off", 1'b0, conversion_busy)
        apb(1, ACS_OFF_CTRL0, 32'h1);
        apb(1, ACS_OFF_CTRL0, 32'h3);
        repeat (10) @(posedge pclk);
        apb(1, ACS_OFF_CTRL0, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK("abort by off", 1'b0, conversion_busy)
        apb(1, ACS_OFF_CTRL0, 32'h1);
        apb(1, ACS_OFF_CTRL0, 32'h3);
        repeat (10) @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        `CHK("abort by reset", 1'b0, conversion_busy)
        presetn <= 1;
        rd_chk(ACS_OFF_CTRL0, 32'h0, "ctrl after reset");
        rd_chk(ACS_OFF_TIMING, 32'h0, "timing after reset");
    endtask
    // Main sequence
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sleep_mode = 0; level = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        regs_scn;
        for (int i = 0; i < 8; i++) begin
            conv_scn({i[0], 1'b0, i[2:0], i[2:0]}, 12'ha5c ^ (12'h111 * i[11:0]), i != 3, 1'b0);
        end
        conv_scn(8'h83, 12'hfff, 1'b1, 1'b1);
        conv_scn(8'h11, 12'h000, 1'b1, 1'b0);
        abort_scn;
        close_out;
    end
endmodule
